// ### ebpa_pkg.sv
`default_nettype none
package ebpa_pkg;

	////////////////////////////////////////////////////////////////////
	// widths and address map

	localparam int ADDR_W = 28;                       // external address
	localparam logic [27:0] PIO_BASE = 28'hffff000;   // peripheral i/o
	localparam logic [27:0] IRAM_LAST = 28'hfffefff;  // top of internal ram
	localparam logic [27:0] REFRESH_ADDR = 28'h0000000; // refresh address

	////////////////////////////////////////////////////////////////////
	// enumerations

	// width of one bus cycle
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_HALF = 2'b01,
		SZ_WORD = 2'b10
	} ebpa_size_t;

	// which party owns the current bus cycle
	typedef enum logic [2:0] {
		OWN_NONE    = 3'b000,
		OWN_HOLD    = 3'b001,
		OWN_REFRESH = 3'b010,
		OWN_DMA     = 3'b011,
		OWN_OP      = 3'b100,
		OWN_FETCH   = 3'b101
	} ebpa_owner_t;

	// arbiter sequencing
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT  = 2'b10,
		ST_HOLD  = 2'b11
	} ebpa_state_t;

endpackage
`default_nettype wire

// ### ebpa_split_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries one access from the arbiter into the misalign splitter
interface ebpa_split_if;
	logic                  load;       // take a new access
	logic [27:0]           addr;       // access byte address
	ebpa_pkg::ebpa_size_t  size;       // access width
	logic                  advance;    // current piece finished
	logic [27:0]           piece_addr; // address of current piece
	ebpa_pkg::ebpa_size_t  piece_size; // width of current piece
	logic                  piece_last; // current piece ends the access

	modport arb (
		output load,
		output addr,
		output size,
		output advance,
		input  piece_addr,
		input  piece_size,
		input  piece_last
	);

	modport split (
		input  load,
		input  addr,
		input  size,
		input  advance,
		output piece_addr,
		output piece_size,
		output piece_last
	);
endinterface
`default_nettype wire

// ### ebpa_splitter.sv
`timescale 1ns/10ps
`default_nettype none
module ebpa_splitter (
	input  wire logic  core_clk,
	input  wire logic  srst,
	ebpa_split_if.split sp
);

	////////////////////////////////////////////////////////////////////
	// piece table: {last, byte offset, width} for piece idx

	function automatic logic [4:0] piece_dec(
		input ebpa_pkg::ebpa_size_t sz,
		input logic [1:0]           a,
		input logic [1:0]           idx
	);
		logic [4:0] r;
		r = {1'b1, 2'b00, ebpa_pkg::SZ_BYTE};
		unique case (sz)
			ebpa_pkg::SZ_WORD:
			begin
				if (a[0])
				begin
					// byte, halfword, byte
					if (idx == 2'd0)
						r = {1'b0, 2'b00, ebpa_pkg::SZ_BYTE};
					else if (idx == 2'd1)
						r = {1'b0, 2'b01, ebpa_pkg::SZ_HALF};
					else
						r = {1'b1, 2'b11, ebpa_pkg::SZ_BYTE};
				end
				else if (a[1])
				begin
					// two halfwords
					if (idx == 2'd0)
						r = {1'b0, 2'b00, ebpa_pkg::SZ_HALF};
					else
						r = {1'b1, 2'b10, ebpa_pkg::SZ_HALF};
				end
				else
					r = {1'b1, 2'b00, ebpa_pkg::SZ_WORD};
			end
			ebpa_pkg::SZ_HALF:
			begin
				// odd halfword becomes two bytes
				if (a[0])
					r = (idx == 2'd0) ? {1'b0, 2'b00, ebpa_pkg::SZ_BYTE}
					                  : {1'b1, 2'b01, ebpa_pkg::SZ_BYTE};
				else
					r = {1'b1, 2'b00, ebpa_pkg::SZ_HALF};
			end
			default:
				r = {1'b1, 2'b00, ebpa_pkg::SZ_BYTE};
		endcase
		return r;
	endfunction

	logic [27:0]          base;   // start address of the access
	ebpa_pkg::ebpa_size_t size_q; // width of the access
	logic [1:0]           idx;    // piece counter
	logic [4:0]           dec;    // decoded current piece

	////////////////////////////////////////////////////////////////////
	// access capture and piece counting

	// any width at any address: pieces walk the table [R6]
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			base   <= 28'h0000000;
			size_q <= ebpa_pkg::SZ_BYTE;
			idx    <= 2'd0;
		end
		else if (sp.load)
		begin
			base   <= sp.addr;
			size_q <= sp.size;
			idx    <= 2'd0;
		end
		else if (sp.advance && !sp.piece_last)
			idx <= idx + 2'd1;
	end

	// piece view from the captured access [R7] [R8] [R9]
	always_comb
	begin
		dec           = piece_dec(size_q, base[1:0], idx);
		sp.piece_last = dec[4];
		sp.piece_addr = base + {26'h0, dec[3:2]};
		sp.piece_size = ebpa_pkg::ebpa_size_t'(dec[1:0]);
	end

	////////////////////////////////////////////////////////////////////
	// checks

	a_half_odd: assert property (@(posedge core_clk) disable iff (srst) // [R7]
		sp.load && sp.size == ebpa_pkg::SZ_HALF && sp.addr[0]
		|=> sp.piece_size == ebpa_pkg::SZ_BYTE && !sp.piece_last)
		else $error("odd halfword does not open with a byte cycle");

	// second piece of an odd halfword closes the access
	a_half_tail: assert property (@(posedge core_clk) // [R7]
		disable iff (srst)
		idx == 2'd1 && size_q == ebpa_pkg::SZ_HALF && base[0]
		|-> sp.piece_size == ebpa_pkg::SZ_BYTE && sp.piece_last
		&& sp.piece_addr == base + 28'h1)
		else $error("odd halfword second piece is not the last byte");

	a_word_odd: assert property (@(posedge core_clk) disable iff (srst) // [R8]
		sp.load && sp.size == ebpa_pkg::SZ_WORD && sp.addr[0]
		|=> sp.piece_size == ebpa_pkg::SZ_BYTE && !sp.piece_last
		&& sp.piece_addr == $past(sp.addr))
		else $error("odd word does not open with a byte cycle");

	a_word_mid: assert property (@(posedge core_clk) disable iff (srst) // [R8]
		idx == 2'd1 && size_q == ebpa_pkg::SZ_WORD && base[0]
		|-> sp.piece_size == ebpa_pkg::SZ_HALF && !sp.piece_last)
		else $error("odd word middle piece is not a halfword");

	a_word_ten: assert property (@(posedge core_clk) disable iff (srst) // [R9]
		sp.load && sp.size == ebpa_pkg::SZ_WORD && sp.addr[1:0] == 2'b10
		|=> sp.piece_size == ebpa_pkg::SZ_HALF && !sp.piece_last)
		else $error("word at offset 2 not split into halfwords");

endmodule
`default_nettype wire

// ### ebpa_arbiter.sv
// Contract
// R1 - priority: hold, refresh, DMA, operand, fetch
// R2 - fetch may sit inside read-modify-write
// R3 - fetch may sit between locked accesses
// R4 - fetch into peripheral area: undefined, no bus
// R5 - no prefetch past internal RAM top
// R6 - any width at any address
// R7 - odd halfword: two byte cycles
// R8 - odd word: byte, halfword, byte
// R9 - word at offset 2: two halfwords
// R10 - arbitrate only between whole bus cycles
`timescale 1ns/10ps
`default_nettype none
module ebpa_arbiter (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic                  hold_req,
	output logic                       hold_ack,
	input  wire logic                  refresh_req,
	output logic                       refresh_done,
	input  wire logic                  dma_req,
	input  wire logic [27:0]           dma_addr,
	input  wire ebpa_pkg::ebpa_size_t  dma_size,
	input  wire logic                  dma_write,
	output logic                       dma_done,
	input  wire logic                  op_req,
	input  wire logic [27:0]           op_addr,
	input  wire ebpa_pkg::ebpa_size_t  op_size,
	input  wire logic                  op_write,
	input  wire logic                  op_rmw,
	input  wire logic                  op_lock,
	output logic                       op_done,
	input  wire logic                  if_req,
	input  wire logic [27:0]           if_addr,
	input  wire logic                  if_prefetch,
	output logic                       if_done,
	output logic                       if_undef,
	output logic                       bus_start,
	output logic [27:0]                bus_addr,
	output ebpa_pkg::ebpa_size_t       bus_size,
	output logic                       bus_write,
	output ebpa_pkg::ebpa_owner_t      bus_owner,
	input  wire logic                  bus_done
);

	////////////////////////////////////////////////////////////////////
	// declarations

	ebpa_split_if sp ();

	logic                  hold_meta;  // first stage, read only by next
	logic                  hold_sync;  // hold request in core domain
	ebpa_pkg::ebpa_state_t state;      // sequencer state
	ebpa_pkg::ebpa_state_t next_state; // sequencer next state
	ebpa_pkg::ebpa_owner_t owner;      // owner of running access
	ebpa_pkg::ebpa_owner_t next_owner; // arbitration winner
	logic                  cur_write;  // running access writes
	logic                  cur_rmw;    // running access is an rmw operand access
	logic                  rmw_gap;    // between rmw read and write
	logic                  atomic;     // only the cpu may use the bus
	logic                  if_pio;     // fetch aims at peripheral area
	logic                  grant;      // a winner is taken this cycle
	logic                  pio_hit;    // fetch answered without the bus
	logic                  fin;        // last piece of an access done

	ebpa_splitter u_split (
		.core_clk (core_clk),
		.srst     (srst),
		.sp       (sp)
	);

	////////////////////////////////////////////////////////////////////
	// hold request arrives from a pin: two-stage synchroniser

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			hold_meta <= 1'b0;
			hold_sync <= 1'b0;
		end
		else
		begin
			hold_meta <= hold_req;
			hold_sync <= hold_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// arbitration

	// the peripheral area is the top of the map, so a compare suffices
	assign if_pio = (if_addr >= ebpa_pkg::PIO_BASE);
	// a locked sequence or an open rmw keeps other masters out
	assign atomic = rmw_gap | op_lock;

	// fixed priority winner, looked at only while idle
	always_comb
	begin
		next_owner = ebpa_pkg::OWN_NONE;
		if (atomic)
		begin
			// fetch is let in inside an rmw pair [R2]
			if (rmw_gap && if_req)
				next_owner = ebpa_pkg::OWN_FETCH;
			else if (op_req)
				next_owner = ebpa_pkg::OWN_OP;
			// fetch still runs between locked accesses [R3]
			else if (if_req)
				next_owner = ebpa_pkg::OWN_FETCH;
		end
		// plain priority chain [R1]
		else if (hold_sync)
			next_owner = ebpa_pkg::OWN_HOLD;
		else if (refresh_req)
			next_owner = ebpa_pkg::OWN_REFRESH;
		else if (dma_req)
			next_owner = ebpa_pkg::OWN_DMA;
		else if (op_req)
			next_owner = ebpa_pkg::OWN_OP;
		else if (if_req)
			next_owner = ebpa_pkg::OWN_FETCH;
	end

	// only an idle bus takes a winner, never mid cycle [R10]
	assign grant = (state == ebpa_pkg::ST_IDLE)
	             && (next_owner != ebpa_pkg::OWN_NONE);
	// peripheral fetches are answered here, no external cycle [R4]
	assign pio_hit = grant && (next_owner == ebpa_pkg::OWN_FETCH) && if_pio;

	////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb
	begin
		next_state = state;
		unique case (state)
			ebpa_pkg::ST_IDLE:
			begin
				if (next_owner == ebpa_pkg::OWN_HOLD)
					next_state = ebpa_pkg::ST_HOLD;
				else if (grant && !pio_hit)
					next_state = ebpa_pkg::ST_ISSUE;
			end
			ebpa_pkg::ST_ISSUE:
				next_state = ebpa_pkg::ST_WAIT;
			ebpa_pkg::ST_WAIT:
			begin
				// the started cycle always runs to its end [R10]
				if (fin)
					next_state = ebpa_pkg::ST_IDLE;
				else if (bus_done)
					next_state = ebpa_pkg::ST_ISSUE;
			end
			ebpa_pkg::ST_HOLD:
			begin
				if (!hold_sync)
					next_state = ebpa_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			state <= ebpa_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// owner and attributes of the running access
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			owner     <= ebpa_pkg::OWN_NONE;
			cur_write <= 1'b0;
			cur_rmw   <= 1'b0;
		end
		// hold takes no owner, so bus_owner falls together with hold_ack
		else if (grant && !pio_hit && next_owner != ebpa_pkg::OWN_HOLD)
		begin
			owner     <= next_owner;
			cur_write <= (next_owner == ebpa_pkg::OWN_DMA) ? dma_write
			           : (next_owner == ebpa_pkg::OWN_OP) ? op_write : 1'b0;
			cur_rmw   <= (next_owner == ebpa_pkg::OWN_OP) && op_rmw;
		end
		else if (state == ebpa_pkg::ST_IDLE)
			owner <= ebpa_pkg::OWN_NONE;
	end

	// rmw window opens after the read, closes when the write is taken
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rmw_gap <= 1'b0;
		else if (fin && owner == ebpa_pkg::OWN_OP && cur_rmw && !cur_write)
			rmw_gap <= 1'b1;
		else if (grant && next_owner == ebpa_pkg::OWN_OP)
			rmw_gap <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// splitter feed: misaligned accesses become several cycles [R6]

	always_comb
	begin
		sp.load = grant && !pio_hit
		        && (next_owner != ebpa_pkg::OWN_HOLD)
		        && (next_owner != ebpa_pkg::OWN_REFRESH);
		sp.addr = if_addr;
		sp.size = ebpa_pkg::SZ_WORD;
		if (next_owner == ebpa_pkg::OWN_DMA)
		begin
			sp.addr = dma_addr;
			sp.size = dma_size;
		end
		else if (next_owner == ebpa_pkg::OWN_OP)
		begin
			sp.addr = op_addr;
			sp.size = op_size;
		end
		sp.advance = (state == ebpa_pkg::ST_WAIT) && bus_done;
	end

	// refresh is one cycle; others end on their last piece
	assign fin = (state == ebpa_pkg::ST_WAIT) && bus_done
	           && (sp.piece_last || owner == ebpa_pkg::OWN_REFRESH);

	////////////////////////////////////////////////////////////////////
	// bus outputs, all registered

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			bus_start <= 1'b0;
			bus_addr  <= 28'h0000000;
			bus_size  <= ebpa_pkg::SZ_BYTE;
			bus_write <= 1'b0;
			bus_owner <= ebpa_pkg::OWN_NONE;
		end
		else
		begin
			bus_start <= (state == ebpa_pkg::ST_ISSUE);
			if (state == ebpa_pkg::ST_ISSUE)
			begin
				bus_addr  <= (owner == ebpa_pkg::OWN_REFRESH)
				           ? ebpa_pkg::REFRESH_ADDR : sp.piece_addr;
				bus_size  <= sp.piece_size;
				bus_write <= cur_write;
			end
			bus_owner <= (next_state == ebpa_pkg::ST_HOLD
			           || state == ebpa_pkg::ST_HOLD && hold_sync)
			           ? ebpa_pkg::OWN_HOLD : owner;
		end
	end

	// the bus is handed out only once the running cycle is over
	always_ff @(posedge core_clk)
	begin
		if (srst)
			hold_ack <= 1'b0;
		else
			hold_ack <= (next_state == ebpa_pkg::ST_HOLD); // [R10]
	end

	////////////////////////////////////////////////////////////////////
	// completion strobes, combinational so a requester drops in time

	assign refresh_done = fin && owner == ebpa_pkg::OWN_REFRESH;
	assign dma_done     = fin && owner == ebpa_pkg::OWN_DMA;
	assign op_done      = fin && owner == ebpa_pkg::OWN_OP;
	assign if_done      = (fin && owner == ebpa_pkg::OWN_FETCH) || pio_hit;
	// a cancelled prefetch past ram top is silent, not undefined [R5]
	assign if_undef     = pio_hit && !if_prefetch; // [R4]

	////////////////////////////////////////////////////////////////////
	// checks

	a_hold_first: assert property (@(posedge core_clk) // [R1]
		disable iff (srst)
		state == ebpa_pkg::ST_IDLE && hold_sync && !atomic
		|=> hold_ack)
		else $error("hold not granted first");

	a_dma_over_op: assert property (@(posedge core_clk) // [R1]
		disable iff (srst)
		state == ebpa_pkg::ST_IDLE && !atomic && !hold_sync
		&& !refresh_req && dma_req && op_req
		|-> ##2 bus_start && bus_owner == ebpa_pkg::OWN_DMA)
		else $error("dma lost to operand access");

	a_rmw_fetch: assert property (@(posedge core_clk) // [R2]
		disable iff (srst)
		state == ebpa_pkg::ST_IDLE && rmw_gap && if_req && !if_pio
		|-> ##2 bus_start && bus_owner == ebpa_pkg::OWN_FETCH)
		else $error("fetch not placed inside rmw");

	a_lock_fetch: assert property (@(posedge core_clk) // [R3]
		disable iff (srst)
		state == ebpa_pkg::ST_IDLE && op_lock && !rmw_gap
		&& !op_req && if_req && !if_pio
		|-> ##2 bus_start && bus_owner == ebpa_pkg::OWN_FETCH)
		else $error("fetch blocked while locked");

	a_pio_nobus: assert property (@(posedge core_clk) // [R4]
		disable iff (srst)
		if_undef |-> if_done ##1 state == ebpa_pkg::ST_IDLE && !bus_start)
		else $error("peripheral fetch went to the bus");

	a_prefetch_cut: assert property (@(posedge core_clk) // [R5]
		disable iff (srst)
		pio_hit && if_prefetch
		|-> if_done && !if_undef ##1 !bus_start)
		else $error("prefetch crossed into peripheral area");

	a_cycle_whole: assert property (@(posedge core_clk) // [R10]
		disable iff (srst)
		state == ebpa_pkg::ST_WAIT && !bus_done && hold_sync
		|=> !hold_ack && state == ebpa_pkg::ST_WAIT)
		else $error("bus taken before cycle ended");

	a_split_pieces: assert property (@(posedge core_clk) // [R6]
		disable iff (srst)
		state == ebpa_pkg::ST_WAIT && bus_done && !fin
		|=> state == ebpa_pkg::ST_ISSUE ##1 bus_start
		&& bus_owner == $past(owner, 2))
		else $error("misaligned access not continued");

endmodule
`default_nettype wire

// ### ebpa_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
// bus controller stand-in: answers each piece after lat cycles
module ebpa_bus_partner (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       bus_start,
	input  wire logic [3:0] lat,
	output logic            bus_done
);
	logic [3:0] cnt; // cycles left on current piece

	////////////////////////////////////////////////////////////
	// load on each piece start; lat of 1 is the fastest answer
	always_ff @(posedge core_clk)
	begin
		if (srst)
			cnt <= 4'h0;
		else if (bus_start)
			cnt <= lat;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end

	// one-cycle answer, low whenever no piece is open
	assign bus_done = (cnt == 4'h1);
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic                  core_clk, srst, hold_req, refresh_req;
	logic                  dma_req, dma_write, op_req, op_write;
	logic                  op_rmw, op_lock, if_req, if_prefetch;
	logic                  hold_ack, refresh_done, dma_done, op_done;
	logic                  if_done, if_undef, bus_start, bus_write;
	logic                  bus_done;           // partner answer
	logic [27:0]           dma_addr, op_addr, if_addr, bus_addr;
	ebpa_pkg::ebpa_size_t  dma_size, op_size, bus_size;
	ebpa_pkg::ebpa_owner_t bus_owner;
	logic [3:0]            lat;                // partner delay
	logic [33:0]           seen[$], want[$];   // {write,owner,size,addr}
	int                    fails, check_count, fdones, undefs;
	localparam logic [33:0] ALL = 34'h3ffffffff;
	localparam logic [33:0] OWNERS = 34'h1c0000000;
	localparam logic [33:0] NO_SIZE = 34'h1cfffffff; // refresh size is junk

	ebpa_arbiter DUT (
		.core_clk(core_clk), .srst(srst), .hold_req(hold_req),
		.hold_ack(hold_ack), .refresh_req(refresh_req),
		.refresh_done(refresh_done), .dma_req(dma_req),
		.dma_addr(dma_addr), .dma_size(dma_size), .dma_write(dma_write),
		.dma_done(dma_done), .op_req(op_req), .op_addr(op_addr),
		.op_size(op_size), .op_write(op_write), .op_rmw(op_rmw),
		.op_lock(op_lock), .op_done(op_done), .if_req(if_req),
		.if_addr(if_addr), .if_prefetch(if_prefetch), .if_done(if_done),
		.if_undef(if_undef), .bus_start(bus_start), .bus_addr(bus_addr),
		.bus_size(bus_size), .bus_write(bus_write),
		.bus_owner(bus_owner), .bus_done(bus_done)
	);
	ebpa_bus_partner bus (.core_clk(core_clk), .srst(srst),
		.bus_start(bus_start), .lat(lat), .bus_done(bus_done));

	////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// requesters drop their request after the done cycle
	always @(posedge core_clk)
	begin
		if (refresh_done === 1'b1) refresh_req <= 1'b0;
		if (dma_done === 1'b1) dma_req <= 1'b0;
		if (op_done === 1'b1) op_req <= 1'b0;
		if (if_done === 1'b1) if_req <= 1'b0;
	end

	// log every bus piece and every fetch answer
	always @(posedge core_clk)
	begin
		if (bus_start === 1'b1)
			seen.push_back({bus_write, bus_owner, bus_size, bus_addr});
		if (if_done === 1'b1) fdones++;
		if (if_undef === 1'b1) undefs++;
	end

	////////////////////////////////////////////////////////////
	task check(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// inputs set by tasks move 1 ns after the edge
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// bounded wait until requests are served; dma may stay refused
	task wait_clear(input logic cpu_only);
		int n;
		n = 0;
		while ((op_req | if_req | (!cpu_only & (dma_req | refresh_req
			| hold_ack))) && n < 300)
		begin
			tick(1);
			n++;
		end
		check(34'(n < 300), 34'h1);
		tick(2);
	endtask

	function logic [33:0] piece(input logic w, input ebpa_pkg::ebpa_owner_t o,
		input logic [1:0] s, input logic [27:0] a);
		return {w, o, s, a};
	endfunction

	task issue_op(input logic [27:0] a, input ebpa_pkg::ebpa_size_t s,
		input logic w);
		op_addr = a;
		op_size = s;
		op_write = w;
		op_req = 1'b1;
	endtask

	task issue_dma(input logic [27:0] a, input ebpa_pkg::ebpa_size_t s,
		input logic w);
		dma_addr = a;
		dma_size = s;
		dma_write = w;
		dma_req = 1'b1;
	endtask

	// expected pieces of one access, from its width and low bits
	task expect_split(input logic w, input ebpa_pkg::ebpa_owner_t o,
		input logic [27:0] a, input ebpa_pkg::ebpa_size_t s);
		if (s == ebpa_pkg::SZ_HALF && a[0])
		begin
			want.push_back(piece(w, o, ebpa_pkg::SZ_BYTE, a));
			want.push_back(piece(w, o, ebpa_pkg::SZ_BYTE, a + 28'h1));
		end
		else if (s == ebpa_pkg::SZ_WORD && a[0])
		begin
			want.push_back(piece(w, o, ebpa_pkg::SZ_BYTE, a));
			want.push_back(piece(w, o, ebpa_pkg::SZ_HALF, a + 28'h1));
			want.push_back(piece(w, o, ebpa_pkg::SZ_BYTE, a + 28'h3));
		end
		else if (s == ebpa_pkg::SZ_WORD && a[1:0] == 2'b10)
		begin
			want.push_back(piece(w, o, ebpa_pkg::SZ_HALF, a));
			want.push_back(piece(w, o, ebpa_pkg::SZ_HALF, a + 28'h2));
		end
		else
			want.push_back(piece(w, o, s, a));
	endtask

	task compare(input logic [33:0] m);
		check(34'(seen.size()), 34'(want.size()));
		for (int i = 0; i < want.size() && i < seen.size(); i++)
			check(seen[i] & m, want[i] & m);
		seen.delete();
		want.delete();
	endtask

	////////////////////////////////////////////////////////////
	// every offset of half and word, op and dma, fast and slow bus
	task t_split;
		ebpa_pkg::ebpa_size_t s;
		logic [27:0]          a;
		for (int k = 0; k < 8; k++)
		begin
			s = (k < 4) ? ebpa_pkg::SZ_HALF : ebpa_pkg::SZ_WORD;
			a = 28'h100 + 28'(k * 16 + k % 4);
			lat = k[1] ? 4'h4 : 4'h1;
			if (k[0]) issue_dma(a, s, 1'b1);
			else issue_op(a, s, 1'b0);
			wait_clear(1'b0);
			expect_split(k[0], k[0] ? ebpa_pkg::OWN_DMA : ebpa_pkg::OWN_OP, a, s);
			compare(ALL);
		end
		lat = 4'h1;
	endtask

	// all requesters pending behind a hold, then served by priority
	task t_prio;
		int n;
		hold_req = 1'b1;
		n = 0;
		while (hold_ack !== 1'b1 && n < 10)
		begin
			tick(1);
			n++;
		end
		check(34'(bus_owner), 34'(ebpa_pkg::OWN_HOLD));
		refresh_req = 1'b1;
		issue_dma(28'h1000, ebpa_pkg::SZ_WORD, 1'b0);
		issue_op(28'h2000, ebpa_pkg::SZ_WORD, 1'b0);
		if_addr = 28'h3000;
		if_req = 1'b1;
		tick(6);
		check(34'(seen.size()), 34'h0);
		hold_req = 1'b0;
		n = 0;
		while (hold_ack === 1'b1 && n < 10)
		begin
			tick(1);
			n++;
		end
		check(34'(n), 34'h3);
		wait_clear(1'b0);
		want.push_back(piece(0, ebpa_pkg::OWN_REFRESH, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_DMA, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_OP, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_FETCH, 0, 0));
		compare(OWNERS);
	endtask

	// hold and refresh raised mid-access wait for the last piece
	task t_atomic;
		int n;
		lat = 4'h5;
		issue_op(28'h201, ebpa_pkg::SZ_WORD, 1'b0);
		n = 0;
		while (seen.size() == 0 && n < 20)
		begin
			tick(1);
			n++;
		end
		refresh_req = 1'b1;
		hold_req = 1'b1;
		n = 0;
		while (hold_ack !== 1'b1 && n < 100)
		begin
			tick(1);
			n++;
		end
		check(34'(hold_ack), 34'h1);
		check(34'(op_req), 34'h0);
		check(34'(seen.size()), 34'h3);
		hold_req = 1'b0;
		wait_clear(1'b0);
		expect_split(0, ebpa_pkg::OWN_OP, 28'h201, ebpa_pkg::SZ_WORD);
		want.push_back(piece(0, ebpa_pkg::OWN_REFRESH, 0, ebpa_pkg::REFRESH_ADDR));
		compare(NO_SIZE);
		lat = 4'h1;
	endtask

	// fetch slips into the rmw gap, dma must wait for the write
	task t_rmw;
		op_rmw = 1'b1;
		issue_op(28'h900, ebpa_pkg::SZ_WORD, 1'b0);
		wait_clear(1'b1);
		op_rmw = 1'b0;
		if_addr = 28'h3100;
		if_req = 1'b1;
		issue_dma(28'ha00, ebpa_pkg::SZ_WORD, 1'b0);
		issue_op(28'h900, ebpa_pkg::SZ_WORD, 1'b1);
		wait_clear(1'b0);
		want.push_back(piece(0, ebpa_pkg::OWN_OP, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_FETCH, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_OP, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_DMA, 0, 0));
		compare(OWNERS);
	endtask

	// locked bus: fetch between locked accesses, dma only after unlock
	task t_lock;
		op_lock = 1'b1;
		issue_op(28'hb00, ebpa_pkg::SZ_WORD, 1'b0);
		wait_clear(1'b1);
		issue_dma(28'hc00, ebpa_pkg::SZ_WORD, 1'b1);
		if_addr = 28'h3200;
		if_req = 1'b1;
		wait_clear(1'b1);
		issue_op(28'hb00, ebpa_pkg::SZ_WORD, 1'b1);
		wait_clear(1'b1);
		op_lock = 1'b0;
		wait_clear(1'b0);
		want.push_back(piece(0, ebpa_pkg::OWN_OP, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_FETCH, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_OP, 0, 0));
		want.push_back(piece(0, ebpa_pkg::OWN_DMA, 0, 0));
		compare(OWNERS);
	endtask

	// fetches into peripheral area: no bus; only a prefetch is clean
	task t_pio;
		int f0, u0;
		for (int k = 0; k < 3; k++)
		begin
			f0 = fdones;
			u0 = undefs;
			if_addr = ebpa_pkg::PIO_BASE + 28'(k * 256);
			if_prefetch = (k == 1);
			if_req = 1'b1;
			wait_clear(1'b1);
			check(34'(fdones - f0), 34'h1);
			check(34'(undefs - u0), 34'(k != 1));
		end
		if_prefetch = 1'b0;
		check(34'(seen.size()), 34'h0);
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{srst, hold_req, refresh_req, dma_req, dma_write} = 5'h10;
		{op_req, op_write, op_rmw, op_lock, if_req, if_prefetch} = 6'h00;
		{dma_addr, op_addr, if_addr} = '0;
		dma_size = ebpa_pkg::SZ_BYTE;
		op_size = ebpa_pkg::SZ_BYTE;
		lat = 4'h1;
		{fails, check_count, fdones, undefs} = '0;
		repeat (6) @(posedge core_clk);
		#1 srst = 1'b0;
		tick(1);
		t_split;
		t_prio;
		t_atomic;
		t_rmw;
		t_lock;
		t_pio;
		end_of_test;
	end

	// watchdog: whole run needs a few hundred cycles
	initial
	begin
		#200000;
		fails++;
		$display("BAD %0t timeout", $time);
		end_of_test;
	end
endmodule
`default_nettype wire
